// >>> logic/atf_pkg.sv
/*
 * Shared types and constants for the identifier-tagged translation buffer
 * and its flush control.
 * Assumes a single core clock and synchronous active-low reset.
 */
package atf_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int ATF_DEPTH   = 8;
    localparam int ATF_IDX_W   = 3;
    localparam int ATF_ASID_W  = 32;
    localparam int ATF_VA_W    = 48;
    localparam int ATF_PG_SH   = 12;
    localparam int ATF_VPN_W   = ATF_VA_W - ATF_PG_SH;
    localparam int ATF_PPN_W   = 28;
    localparam int ATF_RAX_W   = 64;

    // ------------------------------------------------------------------
    // Flush command byte encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] ATF_CMD_NONE     = 8'h00;
    localparam logic [7:0] ATF_CMD_ALL      = 8'h01;
    localparam logic [7:0] ATF_CMD_ASID_ALL = 8'h03;
    localparam logic [7:0] ATF_CMD_ASID_NG  = 8'h07;

    // Per-guest commands implemented
    localparam logic ATF_SEL_FLUSH_CAP = 1'b1;

    // Identifier used outside a guest, and reset values
    localparam logic [ATF_ASID_W-1:0] ATF_HOST_ASID = 32'h0000_0000;
    localparam logic [ATF_IDX_W-1:0]  ATF_IDX_RST   = 3'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ATF_FL_NONE,
        ATF_FL_ALL,
        ATF_FL_ASID_ALL,
        ATF_FL_ASID_NG,
        ATF_FL_PAGE
    } atf_flush_kind_t;

    typedef struct packed {
        logic                  valid;
        logic                  global;
        logic [ATF_ASID_W-1:0] asid;
        logic [ATF_VPN_W-1:0]  vpn;
        logic [ATF_PPN_W-1:0]  ppn;
    } atf_entry_t;

    typedef struct packed {
        atf_flush_kind_t       kind;
        logic [ATF_ASID_W-1:0] asid;
        logic [ATF_VPN_W-1:0]  vpn;
    } atf_flush_t;

    typedef struct packed {
        logic                 req;
        logic                 global;
        logic [ATF_VPN_W-1:0] vpn;
        logic [ATF_PPN_W-1:0] ppn;
    } atf_fill_t;

    typedef struct packed {
        logic                  page_table_base_write;
        logic                  task_switch_base_write;
        logic                  paging_enable_toggle;
        logic                  global_page_enable_toggle;
        logic                  extended_address_toggle;
        logic                  large_page_toggle;
        logic                  feature_control_write;
        logic                  system_management_interrupt;
        logic                  system_management_return;
        logic                  memory_type_range_write;
        logic                  io_range_write;
        logic                  xlat_model_reg_write;
        logic                  intercepted;
        logic                  guest_exit_req;
        logic                  guest_entry_req;
        logic [7:0]            flush_command_byte;
        logic [ATF_ASID_W-1:0] entry_asid;
        logic                  inval_req;
        logic [ATF_RAX_W-1:0]  inval_rax;
        logic [ATF_ASID_W-1:0] inval_ecx;
    } atf_event_t;

endpackage : atf_pkg

// >>> logic/atf_tlb_store.sv
/*
 * Translation entry array: tagged lookup, fill and selective flush.
 * Assumes flush, fill and lookup are never presented in the same cycle.
 */
`timescale 1ns/1ps

module atf_tlb_store
    import atf_pkg::*;
(
    input  wire logic                  mclk_in,
    input  wire logic                  rst_n_in,
    input  wire atf_flush_t            flush_in,
    input  wire atf_fill_t             fill_in,
    input  wire logic                  lk_req_in,
    input  wire logic [ATF_VPN_W-1:0]  lk_vpn_in,
    input  wire logic [ATF_ASID_W-1:0] asid_in,
    input  wire logic                  virt_en_in,
    output logic                       lk_valid_out,
    output logic                       lk_hit_out,
    output logic [ATF_PPN_W-1:0]       lk_ppn_out
);

    atf_entry_t               ent_r [ATF_DEPTH];
    logic [ATF_IDX_W-1:0]     rp_r;
    logic                     hit_nxt;
    logic [ATF_PPN_W-1:0]     ppn_nxt;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic entry_match(atf_entry_t e, logic [ATF_ASID_W-1:0] a,
                                         logic [ATF_VPN_W-1:0] v, logic ven);
        entry_match = e.valid && (e.vpn == v) &&
                      ((e.asid == a) || (e.global && !ven));
    endfunction : entry_match

    function automatic logic flush_hit(atf_entry_t e, atf_flush_t f);
        case (f.kind)
            ATF_FL_ALL:      flush_hit = 1'b1;
            ATF_FL_ASID_ALL: flush_hit = (e.asid == f.asid);
            ATF_FL_ASID_NG:  flush_hit = (e.asid == f.asid) && !e.global;
            ATF_FL_PAGE:     flush_hit = (e.asid == f.asid) && (e.vpn == f.vpn);
            default:         flush_hit = 1'b0;
        endcase
    endfunction : flush_hit

    // ------------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------------
    always_comb
    begin
        hit_nxt = 1'b0;
        ppn_nxt = '0;
        for (int i = 0; i < ATF_DEPTH; i++)
        begin
            if (entry_match(ent_r[i], asid_in, lk_vpn_in, virt_en_in))
            begin
                hit_nxt = 1'b1;
                ppn_nxt = ent_r[i].ppn;
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            lk_valid_out <= 1'b0;
            lk_hit_out   <= 1'b0;
            lk_ppn_out   <= '0;
        end
        else
        begin
            lk_valid_out <= lk_req_in;
            lk_hit_out   <= lk_req_in && hit_nxt;
            lk_ppn_out   <= ppn_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Entry storage
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            rp_r <= ATF_IDX_RST;
            for (int i = 0; i < ATF_DEPTH; i++)
                ent_r[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < ATF_DEPTH; i++)
            begin
                if (flush_hit(ent_r[i], flush_in))
                    ent_r[i].valid <= 1'b0;
            end
            if (fill_in.req)
            begin
                ent_r[rp_r] <= '{valid: 1'b1, global: fill_in.global,
                                 asid: asid_in, vpn: fill_in.vpn,
                                 ppn: fill_in.ppn};
                rp_r        <= rp_r + 3'h1;
            end
        end
    end

endmodule : atf_tlb_store

// >>> logic/atf_flush_ctrl.sv
/*
 * Top of the identifier-tagged translation buffer with flush control:
 * guest entry/exit, flush command byte, architectural flush events and
 * identifier-qualified page invalidation.
 * Assumes all inputs come from core logic on mclk_in, one event per cycle.
 */
`timescale 1ns/1ps

module atf_flush_ctrl
    import atf_pkg::*;
(
    input  wire logic                  mclk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  virt_ext_en_in,
    input  wire atf_event_t            event_in,
    input  wire logic                  lk_req_in,
    input  wire logic [ATF_VA_W-1:0]   lk_vaddr_in,
    input  wire atf_fill_t             fill_in,
    output logic                       lk_valid_out,
    output logic                       lk_hit_out,
    output logic [ATF_PPN_W-1:0]       lk_ppn_out,
    output logic                       busy_out,
    output logic                       entry_done_out,
    output logic                       guest_exit_out,
    output logic                       guest_active_out,
    output logic [ATF_ASID_W-1:0]      cur_asid_out,
    output logic                       reserved_cmd_out,
    output logic                       selective_flush_capability_out
);

    typedef enum logic {
        ATF_IDLE,
        ATF_APPLY
    } atf_state_t;

    atf_state_t            state_r;
    atf_state_t            state_nxt;
    atf_flush_t            flush_r;
    atf_flush_t            flush_nxt;
    logic                  entry_pend_r;
    logic                  entry_pend_nxt;
    logic [ATF_ASID_W-1:0] pend_asid_r;
    logic                  exit_nxt;
    logic                  rsv_nxt;
    logic                  guest_flush_act;
    logic                  idle_ok;
    atf_fill_t             fill_q;
    logic                  lk_q;

    // ------------------------------------------------------------------
    // Command byte decode
    // ------------------------------------------------------------------
    function automatic atf_flush_kind_t decode_cmd(logic [7:0] cmd);
        case (cmd)
            ATF_CMD_NONE:     decode_cmd = ATF_FL_NONE;
            ATF_CMD_ALL:      decode_cmd = ATF_FL_ALL;
            ATF_CMD_ASID_ALL: decode_cmd = ATF_SEL_FLUSH_CAP ? ATF_FL_ASID_ALL
                                                             : ATF_FL_NONE;
            ATF_CMD_ASID_NG:  decode_cmd = ATF_SEL_FLUSH_CAP ? ATF_FL_ASID_NG
                                                             : ATF_FL_NONE;
            default:          decode_cmd = ATF_FL_NONE;
        endcase
    endfunction : decode_cmd

    function automatic logic cmd_reserved(logic [7:0] cmd);
        cmd_reserved = !((cmd == ATF_CMD_NONE) || (cmd == ATF_CMD_ALL) ||
                         (ATF_SEL_FLUSH_CAP &&
                          ((cmd == ATF_CMD_ASID_ALL) || (cmd == ATF_CMD_ASID_NG))));
    endfunction : cmd_reserved

    // ------------------------------------------------------------------
    // Event arbitration
    // ------------------------------------------------------------------
    assign guest_flush_act = event_in.page_table_base_write ||
                             event_in.task_switch_base_write ||
                             event_in.paging_enable_toggle ||
                             event_in.global_page_enable_toggle ||
                             event_in.extended_address_toggle ||
                             event_in.large_page_toggle ||
                             event_in.feature_control_write ||
                             event_in.inval_req;

    always_comb
    begin
        state_nxt      = state_r;
        flush_nxt      = '{kind: ATF_FL_NONE, asid: cur_asid_out, vpn: '0};
        entry_pend_nxt = 1'b0;
        exit_nxt       = 1'b0;
        rsv_nxt        = 1'b0;
        if (state_r == ATF_APPLY)
        begin
            state_nxt = ATF_IDLE;
        end
        else if (event_in.system_management_interrupt ||
                 event_in.system_management_return ||
                 event_in.memory_type_range_write ||
                 event_in.io_range_write ||
                 event_in.xlat_model_reg_write)
        begin
            flush_nxt.kind = ATF_FL_ALL;
            state_nxt      = ATF_APPLY;
        end
        else if (guest_active_out && event_in.guest_exit_req)
        begin
            exit_nxt = 1'b1;
        end
        else if (guest_active_out && event_in.intercepted && guest_flush_act)
        begin
            exit_nxt = 1'b1;
        end
        else if (event_in.guest_entry_req && !guest_active_out)
        begin
            flush_nxt.kind = decode_cmd(event_in.flush_command_byte);
            flush_nxt.asid = event_in.entry_asid;
            rsv_nxt        = cmd_reserved(event_in.flush_command_byte);
            entry_pend_nxt = 1'b1;
            state_nxt      = ATF_APPLY;
        end
        else if (event_in.inval_req)
        begin
            flush_nxt.kind = ATF_FL_PAGE;
            flush_nxt.asid = event_in.inval_ecx;
            flush_nxt.vpn  = event_in.inval_rax[ATF_VA_W-1:ATF_PG_SH];
            state_nxt      = ATF_APPLY;
        end
        else if (event_in.feature_control_write ||
                 event_in.paging_enable_toggle ||
                 event_in.global_page_enable_toggle ||
                 event_in.extended_address_toggle ||
                 event_in.large_page_toggle)
        begin
            flush_nxt.kind = ATF_FL_ASID_ALL;
            state_nxt      = ATF_APPLY;
        end
        else if (event_in.page_table_base_write || event_in.task_switch_base_write)
        begin
            flush_nxt.kind = ATF_FL_ASID_NG;
            state_nxt      = ATF_APPLY;
        end
    end

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state_r      <= ATF_IDLE;
            busy_out     <= 1'b0;
            flush_r      <= '{kind: ATF_FL_NONE, asid: ATF_HOST_ASID, vpn: '0};
            entry_pend_r <= 1'b0;
            pend_asid_r  <= ATF_HOST_ASID;
        end
        else
        begin
            state_r      <= state_nxt;
            busy_out     <= (state_nxt != ATF_IDLE);
            flush_r      <= flush_nxt;
            entry_pend_r <= entry_pend_nxt;
            pend_asid_r  <= event_in.entry_asid;
        end
    end

    // ------------------------------------------------------------------
    // Guest context
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            guest_active_out <= 1'b0;
            cur_asid_out     <= ATF_HOST_ASID;
            entry_done_out   <= 1'b0;
            guest_exit_out   <= 1'b0;
        end
        else
        begin
            entry_done_out <= 1'b0;
            guest_exit_out <= exit_nxt;
            if (exit_nxt)
            begin
                guest_active_out <= 1'b0;
                cur_asid_out     <= ATF_HOST_ASID;
            end
            else if (entry_pend_r)
            begin
                guest_active_out <= 1'b1;
                cur_asid_out     <= pend_asid_r;
                entry_done_out   <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            reserved_cmd_out               <= 1'b0;
            selective_flush_capability_out <= 1'b0;
        end
        else
        begin
            if (rsv_nxt)
                reserved_cmd_out <= 1'b1;
            else if (entry_pend_nxt)
                reserved_cmd_out <= 1'b0;
            selective_flush_capability_out <= ATF_SEL_FLUSH_CAP;
        end
    end

    // ------------------------------------------------------------------
    // Entry array
    // ------------------------------------------------------------------
    assign idle_ok = (state_r == ATF_IDLE) && (state_nxt == ATF_IDLE) &&
                     !exit_nxt;
    assign lk_q    = lk_req_in && idle_ok;

    always_comb
    begin
        fill_q     = fill_in;
        fill_q.req = fill_in.req && idle_ok && !lk_req_in;
    end

    atf_tlb_store i_atf_tlb_store (
        .mclk_in      (mclk_in),
        .rst_n_in     (rst_n_in),
        .flush_in     (flush_r),
        .fill_in      (fill_q),
        .lk_req_in    (lk_q),
        .lk_vpn_in    (lk_vaddr_in[ATF_VA_W-1:ATF_PG_SH]),
        .asid_in      (cur_asid_out),
        .virt_en_in   (virt_ext_en_in),
        .lk_valid_out (lk_valid_out),
        .lk_hit_out   (lk_hit_out),
        .lk_ppn_out   (lk_ppn_out)
    );

endmodule : atf_flush_ctrl

// >>> verification/atf_flush_ctrl_sva.sv
/*
 * Port checker for atf_flush_ctrl.
 * Assumes one core clock and synchronous active-low reset.
 */
`timescale 1ns/1ps

module atf_flush_ctrl_sva
    import atf_pkg::*;
(
    input wire logic                  mclk_in,
    input wire logic                  rst_n_in,
    input wire atf_event_t            event_in,
    input wire logic                  lk_req_in,
    input wire logic                  lk_valid_out,
    input wire logic                  lk_hit_out,
    input wire logic                  busy_out,
    input wire logic                  entry_done_out,
    input wire logic                  guest_exit_out,
    input wire logic                  guest_active_out,
    input wire logic [ATF_ASID_W-1:0] cur_asid_out,
    input wire logic                  reserved_cmd_out,
    input wire logic                  selective_flush_capability_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_host_asid_zero: assert property (!guest_active_out |-> cur_asid_out == '0)
        else $error("identifier not zero outside guest");
    a_exit_leaves_guest: assert property (guest_exit_out |-> !guest_active_out && !busy_out)
        else $error("exit left guest active or flushed");
    a_entry_after_flush: assert property (entry_done_out |-> guest_active_out && $past(busy_out))
        else $error("entry done without preceding flush cycle");
    a_entry_takes_asid: assert property (
        entry_done_out |-> cur_asid_out == $past(event_in.entry_asid, 2))
        else $error("entry identifier not taken");
    a_busy_one_cycle: assert property (busy_out |=> !busy_out)
        else $error("flush lasted more than one cycle");
    a_lookup_answer: assert property (lk_valid_out |-> $past(lk_req_in))
        else $error("lookup result without request");
    a_mgmt_flush: assert property (
        event_in.system_management_interrupt && !busy_out |=> busy_out)
        else $error("management interrupt did not flush");
    a_base_flush: assert property (
        event_in.page_table_base_write && !event_in.intercepted && !busy_out |=> busy_out)
        else $error("base write did not flush");
    a_intercept_exit: assert property (
        guest_active_out && event_in.intercepted && event_in.page_table_base_write
        && !busy_out |=> guest_exit_out && !busy_out)
        else $error("intercepted action did not exit cleanly");
    a_reserved_flag: assert property (
        entry_done_out && !($past(event_in.flush_command_byte, 2) inside {8'h00, 8'h01, 8'h03,
        8'h07}) |-> reserved_cmd_out)
        else $error("reserved command not flagged");
    a_cap_reported: assert property ($past(rst_n_in) |-> selective_flush_capability_out)
        else $error("capability bit not reported");

    c_entry: cover property (entry_done_out);
    c_exit: cover property (guest_exit_out);
    c_hit: cover property (lk_valid_out && lk_hit_out);
    c_reserved: cover property ($rose(reserved_cmd_out));
endmodule : atf_flush_ctrl_sva

bind atf_flush_ctrl atf_flush_ctrl_sva i_atf_flush_ctrl_sva (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .event_in(event_in), .lk_req_in(lk_req_in),
    .lk_valid_out(lk_valid_out), .lk_hit_out(lk_hit_out), .busy_out(busy_out),
    .entry_done_out(entry_done_out), .guest_exit_out(guest_exit_out),
    .guest_active_out(guest_active_out), .cur_asid_out(cur_asid_out),
    .reserved_cmd_out(reserved_cmd_out),
    .selective_flush_capability_out(selective_flush_capability_out)
);

// >>> verification/test_atf_flush_ctrl.sv
/*
 * Self-checking bench for atf_flush_ctrl.
 * Assumes the checker is bound in; inputs change on the falling edge.
 */
`timescale 1ns/1ps

module test_atf_flush_ctrl
    import atf_pkg::*;
    ;
    typedef struct packed {
        logic [7:0] cmd;
        logic [3:0] gm;
        logic [3:0] hm;
        logic       res;
    } atf_row_t;

    // Pages: 1 host plain, 2 host global, 3 guest plain, 4 guest global
    atf_row_t rows [5] = '{
        '{8'h00, 4'hc, 4'h3, 1'b0},
        '{8'h07, 4'h8, 4'h3, 1'b0},
        '{8'h03, 4'h0, 4'h3, 1'b0},
        '{8'h02, 4'hc, 4'h3, 1'b1},
        '{8'h01, 4'h0, 4'h0, 1'b0}};

    logic                 mclk_in = 1'b0;
    logic                 rst_n_in = 1'b0;
    logic                 virt_ext_en_in = 1'b1;
    atf_event_t           event_in = '0;
    logic                 lk_req_in = 1'b0;
    logic [ATF_VA_W-1:0]  lk_vaddr_in = '0;
    atf_fill_t            fill_in = '0;
    logic                 lk_valid_out, lk_hit_out, busy_out, entry_done_out;
    logic                 guest_exit_out, guest_active_out, reserved_cmd_out;
    logic                 selective_flush_capability_out;
    logic [ATF_PPN_W-1:0] lk_ppn_out;
    logic [ATF_ASID_W-1:0] cur_asid_out;
    int                   fails = 0;
    int                   checks_done = 0;

    always #2.5 mclk_in = ~mclk_in;

    atf_flush_ctrl i_atf_flush_ctrl (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .virt_ext_en_in(virt_ext_en_in),
        .event_in(event_in), .lk_req_in(lk_req_in), .lk_vaddr_in(lk_vaddr_in),
        .fill_in(fill_in), .lk_valid_out(lk_valid_out), .lk_hit_out(lk_hit_out),
        .lk_ppn_out(lk_ppn_out), .busy_out(busy_out), .entry_done_out(entry_done_out),
        .guest_exit_out(guest_exit_out), .guest_active_out(guest_active_out),
        .cur_asid_out(cur_asid_out), .reserved_cmd_out(reserved_cmd_out),
        .selective_flush_capability_out(selective_flush_capability_out)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic go(input atf_event_t e);
        @(negedge mclk_in);
        event_in = e;
        @(negedge mclk_in);
        event_in = '0;
    endtask : go

    task automatic look(input int v, input logic hit);
        @(negedge mclk_in);
        lk_req_in   = 1'b1;
        lk_vaddr_in = ATF_VA_W'(v) << ATF_PG_SH;
        @(negedge mclk_in);
        lk_req_in = 1'b0;
        chk(lk_valid_out, 1'b1);
        chk(lk_hit_out, hit);
        if (hit)
            chk(lk_ppn_out, 64'(v + 16));
    endtask : look

    task automatic view(input logic [3:0] m);
        for (int i = 0; i < 4; i++)
            look(i + 1, m[i]);
    endtask : view

    task automatic fill(input int v, input logic g);
        @(negedge mclk_in);
        fill_in = '{1'b1, g, ATF_VPN_W'(v), ATF_PPN_W'(v + 16)};
        @(negedge mclk_in);
        fill_in = '0;
    endtask : fill

    task automatic enter(input logic [7:0] cmd, input int id);
        atf_event_t e;
        e = '0;
        e.guest_entry_req    = 1'b1;
        e.flush_command_byte = cmd;
        e.entry_asid         = ATF_ASID_W'(id);
        go(e);
        @(negedge mclk_in);
        chk(entry_done_out, 1'b1);
        chk(cur_asid_out, 64'(id));
    endtask : enter

    task automatic leave();
        atf_event_t e;
        e = '0;
        e.guest_exit_req = 1'b1;
        go(e);
        chk(guest_exit_out, 1'b1);
        chk(cur_asid_out, 64'h0);
    endtask : leave

    task automatic flush(input atf_event_t e);
        go(e);
        chk(busy_out, 1'b1);
        @(negedge mclk_in);
    endtask : flush

    task automatic prep();
        fill(1, 1'b0);
        fill(2, 1'b1);
        enter(8'h00, 5);
        fill(3, 1'b0);
        fill(4, 1'b1);
        leave();
    endtask : prep

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge mclk_in);
        fails++;
        tally_and_finish();
    end

    initial
    begin
        atf_event_t e;
        repeat (4) @(negedge mclk_in);
        rst_n_in = 1'b1;
        @(negedge mclk_in);
        chk(cur_asid_out, 64'h0);
        chk(guest_active_out, 1'b0);
        chk(selective_flush_capability_out, 64'(ATF_SEL_FLUSH_CAP));
        $display("test reset done");
        foreach (rows[i])
        begin
            prep();
            enter(rows[i].cmd, 5);
            chk(reserved_cmd_out, rows[i].res);
            view(rows[i].gm);
            leave();
            view(rows[i].hm);
            if (i == 0)
            begin
                virt_ext_en_in = 1'b0;
                look(4, 1'b1);
                virt_ext_en_in = 1'b1;
            end
            $display("test row %0d done", i);
        end
        prep();
        e = '0;
        e.page_table_base_write = 1'b1;
        flush(e);
        view(4'h2);
        enter(8'h00, 5);
        view(4'hc);
        e = '0;
        e.task_switch_base_write = 1'b1;
        flush(e);
        view(4'h8);
        e = '0;
        e.feature_control_write = 1'b1;
        flush(e);
        view(4'h0);
        leave();
        view(4'h2);
        $display("test base and feature done");
        for (int k = 0; k < 9; k++)
        begin
            prep();
            e = '0;
            {e.paging_enable_toggle, e.global_page_enable_toggle, e.extended_address_toggle,
             e.large_page_toggle, e.system_management_interrupt, e.system_management_return,
             e.memory_type_range_write, e.io_range_write, e.xlat_model_reg_write} = 9'h100 >> k;
            flush(e);
            view(4'h0);
            enter(8'h00, 5);
            view((k < 4) ? 4'hc : 4'h0);
            leave();
        end
        $display("test management done");
        prep();
        enter(8'h00, 5);
        e = '0;
        e.intercepted           = 1'b1;
        e.page_table_base_write = 1'b1;
        go(e);
        chk(guest_exit_out, 1'b1);
        chk(busy_out, 1'b0);
        view(4'h3);
        enter(8'h00, 5);
        view(4'hc);
        leave();
        $display("test intercept done");
        e = '0;
        e.inval_req = 1'b1;
        e.inval_rax = 64'h1000;
        go(e);
        @(negedge mclk_in);
        view(4'h2);
        e.inval_rax = 64'h3000;
        e.inval_ecx = 32'h5;
        go(e);
        @(negedge mclk_in);
        enter(8'h00, 5);
        view(4'h8);
        leave();
        $display("test page invalidate done");
        enter(8'h00, 5);
        rst_n_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        rst_n_in = 1'b1;
        @(negedge mclk_in);
        chk(cur_asid_out, 64'h0);
        chk(guest_active_out, 1'b0);
        view(4'h0);
        $display("test reset in guest done");
        tally_and_finish();
    end
endmodule : test_atf_flush_ctrl
